// [core/dngp_pkg.sv]
package dngp_pkg;

	localparam int ADDR_W = 16;
	localparam int DATA_W = 32;

	// register indices; byte address is four times the index
	localparam logic [ADDR_W-1:0] IDX_P0_LATCH = 16'h0000;
	localparam logic [ADDR_W-1:0] IDX_P1_LATCH = 16'h0001;
	localparam logic [ADDR_W-1:0] IDX_P0_PIN_READ = 16'h000d;
	localparam logic [ADDR_W-1:0] IDX_P0_DIR = 16'h0f1a;
	localparam logic [ADDR_W-1:0] IDX_P1_DIR = 16'h0f1b;
	localparam logic [ADDR_W-1:0] IDX_P0_PULLUP = 16'h0f27;
	localparam logic [ADDR_W-1:0] IDX_P0_ALT = 16'h0f34;
	localparam logic [ADDR_W-1:0] IDX_P1_CTRL = 16'h0f40;

	localparam logic [3:0] RST_LATCH = 4'h0;
	localparam logic [3:0] RST_DIR = 4'h0;
	localparam logic [3:0] RST_PULLUP = 4'h0;
	localparam logic RST_HF_SEL = 1'h1;
	localparam logic RST_LF_SEL = 1'h0;
	localparam logic RST_P10_PORT = 1'h0;

	localparam int ALT_HF_BIT = 0;
	localparam int ALT_LF_BIT = 2;
	localparam int CTRL_P10_PORT_BIT = 0;

	typedef struct packed {
		logic [3:0] out;
		logic [3:0] oe;
		logic [3:0] pu;
	} dngp_pin_drv_t;

	typedef struct packed {
		logic ext_irq_one_n;
		logic ext_irq_zero_n;
		logic ext_irq_five_n;
		logic ext_rst_n;
	} dngp_p1_alt_t;

endpackage

// [core/dngp_top.sv]
// Decided for this implementation: the Avalon-MM slave port.
`timescale 1ns/1ps
module dngp_top
	import dngp_pkg::*;
(
	input wire logic CLK,
	input wire logic SRST,
	input wire logic CE,
	input wire logic [ADDR_W-1:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [DATA_W-1:0] AVS_WRITEDATA,
	input wire logic [3:0] AVS_BYTEENABLE,
	output logic [DATA_W-1:0] AVS_READDATA,
	output logic AVS_WAITREQUEST,
	input wire logic HF_OSC_ENABLE,
	input wire logic [3:0] P0_IN,
	input wire logic [3:0] P1_IN,
	output dngp_pin_drv_t P0_DRV,
	output dngp_pin_drv_t P1_DRV,
	output logic HF_OSC_INPUT_SELECT,
	output logic LF_OSC_INPUT_SELECT,
	output dngp_p1_alt_t P1_ALT,
	output logic SYSCLK_FACTOR_RST
);

	logic [3:0] port0_output_latch;
	logic [3:0] port1_output_latch;
	logic [3:0] port0_direction;
	logic [3:0] port1_direction;
	logic [3:0] port0_pullup_enable;
	logic hf_osc_input_select;
	logic lf_osc_input_select;
	logic p10_port_mode;
	logic ack;
	logic [3:0] p0_meta;
	logic [3:0] p0_sync;
	logic [3:0] p1_meta;
	logic [3:0] p1_sync;

	// bus decode
	wire req = AVS_READ | AVS_WRITE;
	wire take = req & ack & CE;
	wire wr_low = take & AVS_WRITE & AVS_BYTEENABLE[0];
	wire [ADDR_W-1:0] idx = {2'h0, AVS_ADDRESS[ADDR_W-1:2]};
	wire aligned = AVS_ADDRESS[1:0] == 2'h0;
	wire hit_p0_latch = aligned & (idx == IDX_P0_LATCH);
	wire hit_p1_latch = aligned & (idx == IDX_P1_LATCH);
	wire hit_p0_pin = aligned & (idx == IDX_P0_PIN_READ);
	wire hit_p0_dir = aligned & (idx == IDX_P0_DIR);
	wire hit_p1_dir = aligned & (idx == IDX_P1_DIR);
	wire hit_p0_pu = aligned & (idx == IDX_P0_PULLUP);
	wire hit_p0_alt = aligned & (idx == IDX_P0_ALT);
	wire hit_p1_ctrl = aligned & (idx == IDX_P1_CTRL);

	// one wait cycle, then the answer
	assign AVS_WAITREQUEST = req & ~ack;

	wire [3:0] wd = AVS_WRITEDATA[3:0];

	// pin read gating per oscillator pair
	wire [3:0] p0_alt_mask = {{2{lf_osc_input_select}},
		{2{hf_osc_input_select}}};
	wire [3:0] p0_pin_read = p0_sync & ~port0_direction & ~p0_alt_mask;

	wire [7:0] p0_alt_val = {5'h00, lf_osc_input_select, 1'b0,
		hf_osc_input_select};

	// bits 7..4 and unused bits read as zero
	wire [7:0] rd_mux =
		hit_p0_latch ? {4'h0, port0_output_latch} :
		hit_p1_latch ? {4'h0, port1_output_latch} :
		hit_p0_pin ? {4'h0, p0_pin_read} :
		hit_p0_dir ? {4'h0, port0_direction} :
		hit_p1_dir ? {4'h0, port1_direction} :
		hit_p0_pu ? {4'h0, port0_pullup_enable} :
		hit_p0_alt ? p0_alt_val :
		hit_p1_ctrl ? {7'h00, p10_port_mode} :
		8'h00;

	// leaving hf input select with hf enabled trips a clock reset
	wire next_sysclk_rst = wr_low & hit_p0_alt & HF_OSC_ENABLE &
		hf_osc_input_select & ~wd[ALT_HF_BIT];

	always_ff @(posedge CLK) begin
		if (SRST) begin
			ack <= 1'b0;
			AVS_READDATA <= '0;
			SYSCLK_FACTOR_RST <= 1'b0;
		end else if (CE) begin
			ack <= req & ~ack;
			SYSCLK_FACTOR_RST <= next_sysclk_rst;
			if (req & ~ack) begin
				AVS_READDATA <= {24'h000000, rd_mux};
			end
		end
	end

	// only the writable low bits are stored
	always_ff @(posedge CLK) begin
		if (SRST) begin
			port0_output_latch <= RST_LATCH;
			port1_output_latch <= RST_LATCH;
			port0_direction <= RST_DIR;
			port1_direction <= RST_DIR;
			port0_pullup_enable <= RST_PULLUP;
		end else if (wr_low) begin
			if (hit_p0_latch) begin
				port0_output_latch <= wd;
			end
			if (hit_p1_latch) begin
				port1_output_latch <= wd;
			end
			if (hit_p0_dir) begin
				port0_direction <= wd;
			end
			if (hit_p1_dir) begin
				port1_direction <= wd;
			end
			if (hit_p0_pu) begin
				port0_pullup_enable <= wd;
			end
		end
	end

	always_ff @(posedge CLK) begin
		if (SRST) begin
			hf_osc_input_select <= RST_HF_SEL;
			lf_osc_input_select <= RST_LF_SEL;
			p10_port_mode <= RST_P10_PORT;
		end else if (wr_low) begin
			if (hit_p0_alt) begin
				hf_osc_input_select <= wd[ALT_HF_BIT];
				lf_osc_input_select <= wd[ALT_LF_BIT];
			end
			if (hit_p1_ctrl) begin
				p10_port_mode <= wd[CTRL_P10_PORT_BIT];
			end
		end
	end

	// pins are asynchronous to CLK
	always_ff @(posedge CLK) begin
		if (SRST) begin
			p0_meta <= 4'h0;
			p0_sync <= 4'h0;
			p1_meta <= 4'h0;
			p1_sync <= 4'h0;
		end else if (CE) begin
			p0_meta <= P0_IN;
			p0_sync <= p0_meta;
			p1_meta <= P1_IN;
			p1_sync <= p1_meta;
		end
	end

	// port0 drive; oscillator pins are never driven as ports
	wire [3:0] p0_oe = port0_direction & ~p0_alt_mask;
	assign P0_DRV.out = port0_output_latch;
	assign P0_DRV.oe = p0_oe;
	assign P0_DRV.pu = port0_pullup_enable & ~port0_direction;
	assign HF_OSC_INPUT_SELECT = hf_osc_input_select;
	assign LF_OSC_INPUT_SELECT = lf_osc_input_select;

	// port1 drive; bit0 stays an input while it is the reset pin
	wire p1_rst_pin = ~p10_port_mode;
	assign P1_DRV.out = port1_output_latch;
	assign P1_DRV.oe = port1_direction & {3'h7, ~p1_rst_pin};
	// no pull-up register for port1 here
	assign P1_DRV.pu = 4'h0;

	// irq inputs idle high while the bit is an output; ext_rst_n idles high while bit0 is in port mode
	wire [3:0] p1_in_mode = ~port1_direction;
	assign P1_ALT.ext_irq_one_n = p1_sync[3] | ~p1_in_mode[3];
	assign P1_ALT.ext_irq_zero_n = p1_sync[2] | ~p1_in_mode[2];
	assign P1_ALT.ext_irq_five_n = p1_sync[1] | ~p1_in_mode[1];
	assign P1_ALT.ext_rst_n = p1_sync[0] | ~p1_rst_pin;

endmodule

// [tb/dngp_monitor.sv]
`timescale 1ns/1ps
module dngp_monitor
	import dngp_pkg::*;
(
	input wire logic CLK,
	input wire logic SRST,
	input wire logic HF_OSC_ENABLE,
	input wire dngp_pin_drv_t P0_DRV,
	input wire dngp_pin_drv_t P1_DRV,
	input wire logic HF_OSC_INPUT_SELECT,
	input wire logic LF_OSC_INPUT_SELECT,
	input wire logic SYSCLK_FACTOR_RST
);
	default clocking @(posedge CLK); endclocking
	default disable iff (SRST);
	a_pu_off: assert property (!(P0_DRV.pu & P0_DRV.oe)) else $error("pu");
	a_hf_oe: assert property (HF_OSC_INPUT_SELECT |-> !P0_DRV.oe[1:0])
		else $error("hf pins driven");
	a_lf_oe: assert property (LF_OSC_INPUT_SELECT |-> !P0_DRV.oe[3:2])
		else $error("lf pins driven");
	a_cr_cause: assert property (SYSCLK_FACTOR_RST |->
		$fell(HF_OSC_INPUT_SELECT)) else $error("stray clock reset");
	a_cr_fires: assert property ($fell(HF_OSC_INPUT_SELECT) &&
		$past(HF_OSC_ENABLE) |-> SYSCLK_FACTOR_RST) else $error("no reset");
	a_cr_once: assert property (SYSCLK_FACTOR_RST |=> !SYSCLK_FACTOR_RST)
		else $error("long reset pulse");
	a_alt_rst: assert property ($fell(SRST) |-> HF_OSC_INPUT_SELECT &&
		!LF_OSC_INPUT_SELECT) else $error("alt reset value");
	a_dir_rst: assert property ($fell(SRST) |-> !P0_DRV.oe &&
		!P1_DRV.oe) else $error("pin driven after reset");
endmodule

// [tb/dngp_pins.sv]
`timescale 1ns/1ps
module dngp_pins
	import dngp_pkg::*;
(
	input wire dngp_pin_drv_t P0_DRV,
	input wire dngp_pin_drv_t P1_DRV,
	input wire logic [7:0] far,
	output logic [3:0] P0_IN,
	output logic [3:0] P1_IN
);
	// weak far side: a pull-up lifts it
	assign P0_IN = P0_DRV.oe & P0_DRV.out | ~P0_DRV.oe & (P0_DRV.pu | far[3:0]);
	assign P1_IN = P1_DRV.oe & P1_DRV.out | ~P1_DRV.oe & (P1_DRV.pu | far[7:4]);
endmodule

// [tb/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
	import dngp_pkg::*;
	logic CLK = 0, SRST = 1, HF_OSC_ENABLE = 0, AVS_READ = 0, AVS_WRITE = 0;
	logic AVS_WAITREQUEST, HF_OSC_INPUT_SELECT, LF_OSC_INPUT_SELECT, seen = 0;
	logic SYSCLK_FACTOR_RST;
	dngp_p1_alt_t P1_ALT;
	logic [15:0] AVS_ADDRESS = 0;
	logic [31:0] AVS_WRITEDATA = 0, AVS_READDATA;
	logic [3:0] P0_IN, P1_IN;
	dngp_pin_drv_t P0_DRV, P1_DRV;
	int num_errors = 0, tests_run = 0;
	dngp_top dngp_top_inst (.CLK, .SRST, .CE(1'b1), .AVS_ADDRESS, .AVS_READ,
		.AVS_WRITE, .AVS_WRITEDATA, .AVS_BYTEENABLE(4'hf), .AVS_READDATA,
		.AVS_WAITREQUEST, .HF_OSC_ENABLE, .P0_IN, .P1_IN, .P0_DRV, .P1_DRV,
		.HF_OSC_INPUT_SELECT, .LF_OSC_INPUT_SELECT, .P1_ALT,
		.SYSCLK_FACTOR_RST);
	dngp_pins dngp_pins_inst (.P0_DRV, .P1_DRV, .far(8'h08), .P0_IN, .P1_IN);
	initial forever #5 CLK = ~CLK;
	always @(posedge CLK) if (SYSCLK_FACTOR_RST === 1'b1) seen <= 1;
	task complete_run;
		if (num_errors == 0 && tests_run > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task chk(input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e) num_errors++;
		if (s !== e) $display("BAD %0t %h %h", $time, s, e);
	endtask
	// a read compares d with the data registered one edge before the accepting edge
	task automatic bus(logic w, logic [15:0] a, logic [31:0] d);
		int n = 0;
		// one idle edge keeps release and next request apart
		@(posedge CLK);
		AVS_WRITE <= w;
		AVS_READ <= ~w;
		AVS_ADDRESS <= a;
		AVS_WRITEDATA <= d;
		do @(posedge CLK); while (AVS_WAITREQUEST !== 1'b0 && ++n < 50);
		if (n == 50) chk(0, 1);
		if (n == 50) complete_run;
		if (!w) chk(AVS_READDATA, d);
		AVS_WRITE <= 0;
		AVS_READ <= 0;
	endtask
	task t_regs;
		bus(0, 16'h3cd0, 32'h1);
		chk(32'(P1_ALT), 32'h0);
		bus(1, 16'h0000, 32'hff);
		bus(1, 16'h3c68, 32'hfc);
		bus(1, 16'h0004, 32'h5);
		bus(1, 16'h3c6c, 32'hf);
		bus(0, 16'h0000, 32'hf);
		chk(32'({P0_DRV.oe, P1_DRV.out, P1_DRV.oe}), 32'hc5e);
		chk(32'(P1_ALT), 32'he);
		bus(0, 16'h0034, 32'h0);
		bus(0, 16'h0100, 32'h0);
	endtask
	task t_osc;
		bus(1, 16'h3c68, 32'h0);
		bus(1, 16'h3cd0, 32'h0);
		bus(1, 16'h3c9c, 32'h3);
		repeat (3) @(posedge CLK);
		bus(0, 16'h0034, 32'hb);
		HF_OSC_ENABLE <= 1;
		bus(1, 16'h3cd0, 32'hff);
		bus(0, 16'h3cd0, 32'h5);
		chk(32'(seen), 32'h0);
		bus(1, 16'h3cd0, 32'h4);
		bus(0, 16'h3cd0, 32'h4);
		chk(32'(seen), 32'h1);
	endtask
	// mid-run reset must restore the alt, port0 latch and port0 direction registers
	task t_reset;
		SRST <= 1;
		repeat (2) @(posedge CLK);
		SRST <= 0;
		bus(0, 16'h3cd0, 32'h1);
		bus(0, 16'h0000, 32'h0);
		bus(0, 16'h3c68, 32'h0);
	endtask
	initial begin
		repeat (4) @(posedge CLK);
		SRST <= 0;
		t_regs;
		t_osc;
		t_reset;
		complete_run;
	end
endmodule
bind dngp_top dngp_monitor dngp_monitor_inst (.CLK, .SRST, .HF_OSC_ENABLE,
	.P0_DRV, .P1_DRV, .HF_OSC_INPUT_SELECT, .LF_OSC_INPUT_SELECT,
	.SYSCLK_FACTOR_RST);
